// [logic/mbic_consts.vh]
`ifndef MBIC_CONSTS_VH
`define MBIC_CONSTS_VH
// Vector addresses at the top of memory
`define MBIC_VEC_RESTART_HI 16'hFFFE
`define MBIC_VEC_RESTART_LO 16'hFFFF
`define MBIC_VEC_NMI_HI 16'hFFFC
`define MBIC_VEC_NMI_LO 16'hFFFD
`define MBIC_VEC_TRAP_HI 16'hFFFA
`define MBIC_VEC_TRAP_LO 16'hFFFB
`define MBIC_VEC_IRQ_HI 16'hFFF8
`define MBIC_VEC_IRQ_LO 16'hFFF9
// Condition code layout
`define MBIC_CC_MASK_BIT 4
`define MBIC_CC_ONES 8'hC0
`define MBIC_CC_ONES_HI 2'b11
`define MBIC_CC_RESET 8'hD0
// Address lines forced high during reset
`define MBIC_ADDR_ALL_HIGH 16'hFFFF
// Float delay limit in ns and clock period in ns
`define MBIC_FLOAT_NS 500
`define MBIC_CLK_NS 10
// Reset stacking pointer value
`define MBIC_SP_RESET 16'h01FF
`endif

// [logic/mbic_edge_sync.v]
`timescale 1ns/100ps
// Samples the non-maskable request input and finds its falling edge
module mbic_edge_sync (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_arst_n,
	// Raw inputs
	input wire i_nmi_n,
	// Edge event
	output reg o_nmi_fall
);
	// Previous level of the non-maskable request
	reg nmi_prev_r;

	// Edge detector; idle level is high so reset loads one
	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			nmi_prev_r <= 1'b1;
			o_nmi_fall <= 1'b0;
		end else begin
			nmi_prev_r <= i_nmi_n;
			o_nmi_fall <= nmi_prev_r & ~i_nmi_n;
		end
	end
endmodule // mbic_edge_sync

// [logic/mbic_bus_ctrl.v]
`timescale 1ns/100ps
`include "mbic_consts.vh"
module mbic_bus_ctrl #(
	parameter ADDR_W = 16,
	parameter DATA_W = 8
) (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_arst_n,
	// Bus control inputs
	input wire i_address_float_control,
	input wire i_data_drive_enable,
	input wire i_halt_n,
	input wire i_irq_n,
	input wire i_nmi_n,
	// Instruction sequencer handshake
	input wire i_insn_done,
	input wire i_sleep_until_event_op,
	input wire i_software_trap_op,
	input wire i_cc_mask_clear,
	input wire [ADDR_W-1:0] i_pc,
	input wire [ADDR_W-1:0] i_index,
	input wire [DATA_W-1:0] i_acc_a,
	input wire [DATA_W-1:0] i_acc_b,
	input wire [DATA_W-1:0] i_cc,
	// Data lines in
	input wire [DATA_W-1:0] i_data_lines,
	// Address lines
	output reg [ADDR_W-1:0] o_address_lines,
	output reg o_address_lines_oe_n,
	// Read/write line
	output reg o_rw,
	output reg o_rw_oe_n,
	// Data lines out
	output reg [DATA_W-1:0] o_data_lines,
	output reg o_data_lines_oe_n,
	// Status
	output reg o_valid_address_strobe,
	output reg o_bus_released,
	output reg [DATA_W-1:0] o_cc,
	output reg [ADDR_W-1:0] o_pc_load,
	output reg o_pc_load_valid,
	output reg o_busy
);
	// Sequencer states
	localparam ST_RUN = 3'd0;
	localparam ST_VEC_HI = 3'd1;
	localparam ST_VEC_LO = 3'd2;
	localparam ST_STACK = 3'd3;
	localparam ST_HALT = 3'd4;
	localparam ST_SLEEP = 3'd5;
	localparam ST_RESTART = 3'd6;
	localparam ST_VEC_ADDR = 3'd7; // Vector high address set up, on the bus next cycle

	// Float delay in cycles, round down, at least one
	localparam integer FLOAT_CYC = (`MBIC_FLOAT_NS / `MBIC_CLK_NS) < 1 ? 1 :
		(`MBIC_FLOAT_NS / `MBIC_CLK_NS);

	// Entry kinds
	localparam K_RST = 2'd0;
	localparam K_NMI = 2'd1;
	localparam K_TRAP = 2'd2;
	localparam K_IRQ = 2'd3;

	// Vector high address per entry kind
	function [ADDR_W-1:0] vec_hi;
		input [1:0] k;
		begin
			case (k)
				K_RST: vec_hi = `MBIC_VEC_RESTART_HI;
				K_NMI: vec_hi = `MBIC_VEC_NMI_HI;
				K_TRAP: vec_hi = `MBIC_VEC_TRAP_HI;
				default: vec_hi = `MBIC_VEC_IRQ_HI;
			endcase
		end
	endfunction

	// Vector low address per entry kind
	function [ADDR_W-1:0] vec_lo;
		input [1:0] k;
		begin
			case (k)
				K_RST: vec_lo = `MBIC_VEC_RESTART_LO;
				K_NMI: vec_lo = `MBIC_VEC_NMI_LO;
				K_TRAP: vec_lo = `MBIC_VEC_TRAP_LO;
				default: vec_lo = `MBIC_VEC_IRQ_LO;
			endcase
		end
	endfunction

	reg [2:0] state_r; // Sequencer state
	reg [1:0] kind_r; // Entry being served
	reg [2:0] push_r; // Stack byte index
	reg [ADDR_W-1:0] sp_r; // Stack pointer
	reg [DATA_W-1:0] cc_r; // Condition codes
	reg [DATA_W-1:0] vhi_r; // Fetched vector high byte
	reg nmi_pend_r; // Latched non-maskable edge
	reg irq_r; // Sampled maskable level
	reg sleep_r; // Sleep op waiting for a wake request
	reg float_r; // Float request seen
	reg [9:0] float_cnt_r; // Cycles since float request
	wire nmi_fall; // Edge from helper

	// Falling-edge finder for non-maskable requests
	mbic_edge_sync u_edge (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.i_nmi_n(i_nmi_n),
		.o_nmi_fall(nmi_fall)
	);

	// Byte pushed for each stack index
	reg [DATA_W-1:0] push_byte;
	always @* begin
		case (push_r)
			3'd0: push_byte = i_pc[7:0];
			3'd1: push_byte = i_pc[15:8];
			3'd2: push_byte = i_index[7:0];
			3'd3: push_byte = i_index[15:8];
			3'd4: push_byte = i_acc_a;
			3'd5: push_byte = i_acc_b;
			default: push_byte = cc_r;
		endcase
	end

	// Float timing counter; floats within the limit
	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			float_r <= 1'b0;
			float_cnt_r <= 10'h000;
		end else if (!i_address_float_control) begin
			float_r <= 1'b0;
			float_cnt_r <= 10'h000;
		end else begin
			float_r <= 1'b1;
			if (float_cnt_r < FLOAT_CYC[9:0])
				float_cnt_r <= float_cnt_r + 10'h001;
		end
	end

	// Main sequencer
	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_r <= ST_RESTART;
			kind_r <= K_RST;
			push_r <= 3'd0;
			sp_r <= `MBIC_SP_RESET;
			cc_r <= `MBIC_CC_RESET;
			vhi_r <= 8'h00;
			nmi_pend_r <= 1'b0;
			irq_r <= 1'b0;
			sleep_r <= 1'b0;
			o_pc_load <= 16'h0000;
			o_pc_load_valid <= 1'b0;
		end else begin
			o_pc_load_valid <= 1'b0;
			irq_r <= ~i_irq_n;
			if (nmi_fall)
				nmi_pend_r <= 1'b1;
			else if ((state_r == ST_STACK && kind_r == K_NMI) ||
				(state_r == ST_SLEEP && nmi_pend_r))
				nmi_pend_r <= 1'b0;
			// Software clears the mask
			if (i_cc_mask_clear && state_r == ST_RUN)
				cc_r[`MBIC_CC_MASK_BIT] <= 1'b0;
			case (state_r)
				ST_RESTART: begin
					kind_r <= K_RST;
					state_r <= ST_VEC_HI;
				end
				ST_RUN: begin
					if (i_insn_done) begin
						if (!i_halt_n)
							state_r <= ST_HALT;
						else if (nmi_pend_r || nmi_fall) begin
							kind_r <= K_NMI;
							push_r <= 3'd0;
							state_r <= ST_STACK;
						end else if (irq_r && !cc_r[`MBIC_CC_MASK_BIT]) begin
							kind_r <= K_IRQ;
							push_r <= 3'd0;
							state_r <= ST_STACK;
						end else if (i_software_trap_op) begin
							kind_r <= K_TRAP;
							push_r <= 3'd0;
							state_r <= ST_STACK;
						end else if (i_sleep_until_event_op) begin
							// Registers are saved before sleeping
							kind_r <= K_IRQ;
							// The op is a one-cycle level, so remember it
							sleep_r <= 1'b1;
							push_r <= 3'd0;
							state_r <= ST_STACK;
						end
					end
				end
				ST_STACK: begin
					sp_r <= sp_r - 16'h0001;
					if (push_r == 3'd6) begin
						if (sleep_r)
							state_r <= ST_SLEEP;
						else begin
							if (kind_r != K_NMI)
								cc_r[`MBIC_CC_MASK_BIT] <= 1'b1;
							// Last push still owns the bus next cycle
							state_r <= ST_VEC_ADDR;
						end
					end else
						push_r <= push_r + 3'd1;
				end
				ST_SLEEP: begin
					if (nmi_pend_r) begin
						kind_r <= K_NMI;
						sleep_r <= 1'b0;
						state_r <= ST_VEC_ADDR;
					end else if (irq_r && !cc_r[`MBIC_CC_MASK_BIT]) begin
						kind_r <= K_IRQ;
						sleep_r <= 1'b0;
						cc_r[`MBIC_CC_MASK_BIT] <= 1'b1;
						state_r <= ST_VEC_ADDR;
					end
				end
				ST_VEC_ADDR: begin
					// Vector high address goes out, byte read next
					state_r <= ST_VEC_HI;
				end
				ST_VEC_HI: begin
					vhi_r <= i_data_lines;
					state_r <= ST_VEC_LO;
				end
				ST_VEC_LO: begin
					o_pc_load <= {vhi_r, i_data_lines};
					o_pc_load_valid <= 1'b1;
					state_r <= ST_RUN;
				end
				ST_HALT: begin
					if (i_halt_n)
						state_r <= ST_RUN;
				end
				default: state_r <= ST_RUN;
			endcase
			cc_r[7:6] <= `MBIC_CC_ONES_HI;
		end
	end

	// Registered bus outputs
	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_address_lines <= `MBIC_ADDR_ALL_HIGH;
			o_address_lines_oe_n <= 1'b0;
			o_rw <= 1'b1;
			o_rw_oe_n <= 1'b0;
			o_data_lines <= 8'h00;
			o_data_lines_oe_n <= 1'b1;
			o_valid_address_strobe <= 1'b0;
			o_bus_released <= 1'b0;
			o_cc <= `MBIC_CC_RESET;
			o_busy <= 1'b1;
		end else begin
			o_cc <= cc_r;
			o_busy <= (state_r != ST_RUN);
			case (state_r)
				ST_RESTART: o_address_lines <= vec_hi(K_RST);
				ST_VEC_HI: o_address_lines <= vec_lo(kind_r);
				ST_STACK: o_address_lines <= sp_r;
				ST_VEC_ADDR: o_address_lines <= vec_hi(kind_r);
				ST_SLEEP: o_address_lines <= vec_hi(kind_r);
				default: o_address_lines <= i_pc;
			endcase
			o_rw <= ~(state_r == ST_STACK);
			o_data_lines <= push_byte;
			o_address_lines_oe_n <= float_r | i_address_float_control |
				(state_r == ST_HALT) | (state_r == ST_SLEEP);
			o_rw_oe_n <= float_r | i_address_float_control | (state_r == ST_HALT) |
				(state_r == ST_SLEEP);
			o_data_lines_oe_n <= ~(i_data_drive_enable && state_r == ST_STACK);
			// strobe only with valid address
			// Strobe waits until the address drivers are back on
			o_valid_address_strobe <= ~i_address_float_control && ~float_r &&
				state_r != ST_HALT && state_r != ST_SLEEP;
			o_bus_released <= ~i_address_float_control && ~float_r &&
				(state_r == ST_HALT || state_r == ST_SLEEP);
		end
	end
endmodule // mbic_bus_ctrl

// [dv/mbic_mem_model.sv]
`timescale 1ns/100ps
// Far-side memory: a fixed byte pattern on reads, every written byte queued
module mbic_mem_model (
	input wire i_clk_sys,
	input wire [15:0] i_addr,
	input wire i_addr_oe_n,
	input wire i_rw,
	input wire i_strobe,
	input wire [7:0] i_wdata,
	input wire i_wdata_oe_n,
	output wire [7:0] o_rdata
);
	logic [7:0] wq[$]; // Written bytes in bus order
	logic [7:0] last_r = 8'h00; // Byte shown last cycle
	// Contents seen at any address
	function automatic [7:0] mv(input [15:0] a);
		mv = a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction
	// strobe qualifies reads
	// Unselected or floated: toggle, so a stale byte never looks valid
	assign o_rdata = (i_addr_oe_n || !i_strobe) ? ~last_r : mv(i_addr);
	// Capture only bytes that the controller really drives
	always @(posedge i_clk_sys) begin
		last_r <= o_rdata;
		if (i_strobe && !i_rw && !i_wdata_oe_n)
			wq.push_back(i_wdata);
	end
endmodule // mbic_mem_model

// [dv/mbic_props.sv]
`timescale 1ns/100ps
// Port-level checks of the bus controller
module mbic_props (
	input wire i_clk_sys,
	input wire i_arst_n,
	input wire i_address_float_control,
	input wire i_data_drive_enable,
	input wire i_halt_n,
	input wire i_irq_n,
	input wire i_insn_done,
	input wire [15:0] o_address_lines,
	input wire o_address_lines_oe_n,
	input wire o_rw,
	input wire o_rw_oe_n,
	input wire o_data_lines_oe_n,
	input wire o_valid_address_strobe,
	input wire o_bus_released,
	input wire [7:0] o_cc,
	input wire o_busy
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);
	// Maskable request seen at an instruction end while running
	wire take = i_insn_done && !o_busy && i_halt_n && !i_irq_n;
	restart_seq_a: assert property (
		$rose(i_arst_n) |-> o_address_lines == 16'hFFFF ##1 o_address_lines == 16'hFFFE
		##1 o_address_lines == 16'hFFFF) else $error("restart vector order wrong");
	reset_mask_a: assert property ($rose(i_arst_n) |-> o_cc == 8'hD0)
		else $error("mask not set by restart");
	float_lines_a: assert property (i_address_float_control |=> o_address_lines_oe_n &&
		o_rw_oe_n && !o_valid_address_strobe && !o_bus_released) else $error("float ignored");
	data_enable_a: assert property (!i_data_drive_enable |=> o_data_lines_oe_n)
		else $error("data driven without enable");
	read_quiet_a: assert property (!o_rw_oe_n && o_rw |-> o_data_lines_oe_n)
		else $error("data driven in read");
	strobe_addr_a: assert property (o_valid_address_strobe |-> !o_address_lines_oe_n)
		else $error("strobe without address");
	released_quiet_a: assert property (o_bus_released |-> !o_valid_address_strobe &&
		o_address_lines_oe_n && o_rw_oe_n) else $error("released bus still driven");
	cc_ones_a: assert property (o_cc[7:6] == 2'b11)
		else $error("unused cc bits not one");
	irq_vector_a: assert property (take && !o_cc[4] |-> ##[2:20]
		o_address_lines == 16'hFFF8 ##1 o_address_lines == 16'hFFF9) else $error("irq vector");
	masked_irq_a: assert property (take && o_cc[4] |-> ##2 !o_busy)
		else $error("masked request taken");
	cover property (take && !o_cc[4]);
	cover property (o_bus_released && i_halt_n);
	cover property (i_address_float_control);
endmodule // mbic_props

// [dv/tb_top.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
`define TILL(s, v) begin n = 0; while ((s) !== (v) && n < 60) begin \
	@(negedge i_clk_sys); n++; end `CHK(s, v) end
// Acts as the instruction sequencer and checks every entry against the model
module tb_top;
	logic i_clk_sys = 0, i_arst_n = 0, i_address_float_control = 0, i_data_drive_enable = 1;
	logic i_halt_n = 1, i_irq_n = 1, i_nmi_n = 1, i_insn_done = 0, i_sleep_until_event_op = 0;
	logic i_software_trap_op = 0, i_cc_mask_clear = 0;
	logic [15:0] i_pc = 0, i_index = 0, o_address_lines, o_pc_load;
	logic [7:0] i_acc_a = 0, i_acc_b = 0, i_cc = 0, i_data_lines, o_data_lines, o_cc, rd;
	logic o_address_lines_oe_n, o_rw, o_rw_oe_n, o_data_lines_oe_n;
	logic o_valid_address_strobe, o_bus_released, o_pc_load_valid, o_busy;
	int fail_count = 0, checked = 0, cyc = 0, n;
	logic [31:0] seed = 19;
	bit mask = 1; // Expected mask flag
	always #5 i_clk_sys = ~i_clk_sys;
	// Data wire: controller wins while it drives
	assign i_data_lines = o_data_lines_oe_n ? rd : o_data_lines;
	mbic_bus_ctrl mbic_bus_ctrl_inst (.i_clk_sys, .i_arst_n, .i_address_float_control,
		.i_data_drive_enable, .i_halt_n, .i_irq_n, .i_nmi_n, .i_insn_done,
		.i_sleep_until_event_op, .i_software_trap_op, .i_cc_mask_clear, .i_pc, .i_index,
		.i_acc_a, .i_acc_b, .i_cc, .i_data_lines, .o_address_lines, .o_address_lines_oe_n,
		.o_rw, .o_rw_oe_n, .o_data_lines, .o_data_lines_oe_n, .o_valid_address_strobe,
		.o_bus_released, .o_cc, .o_pc_load, .o_pc_load_valid, .o_busy);
	mbic_mem_model mbic_mem_model_inst (.i_clk_sys, .i_addr(o_address_lines),
		.i_addr_oe_n(o_address_lines_oe_n), .i_rw(o_rw), .i_strobe(o_valid_address_strobe),
		.i_wdata(o_data_lines), .i_wdata_oe_n(o_data_lines_oe_n), .o_rdata(rd));
	function automatic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Entry kinds: 0 maskable, 1 non-maskable, 2 trap op, 3 sleep op woken by non-maskable
	task automatic entry(input int k, input [15:0] v);
		logic [7:0] e[$];
		@(negedge i_clk_sys);
		{i_pc, i_index} = rnd();
		{i_acc_a, i_acc_b, i_cc} = 24'(rnd());
		e = {i_pc[7:0], i_pc[15:8], i_index[7:0], i_index[15:8], i_acc_a, i_acc_b, 8'hC0};
		e[6][4] = mask;
		mbic_mem_model_inst.wq.delete();
		i_irq_n = (k != 0);
		i_nmi_n = (k != 1);
		// Requests are sampled a cycle ahead, so they lead the instruction end
		if (k < 2)
			repeat (3) @(negedge i_clk_sys);
		i_software_trap_op = (k == 2);
		i_sleep_until_event_op = (k == 3);
		i_insn_done = 1;
		@(negedge i_clk_sys);
		i_insn_done = 0;
		i_software_trap_op = 0;
		i_sleep_until_event_op = 0;
		i_irq_n = 1;
		if (k == 3) begin
			`TILL(o_bus_released, 1'b1)
			i_nmi_n = 0;
		end
		`TILL(o_pc_load_valid, 1'b1)
		`CHK(o_pc_load, {mbic_mem_model_inst.mv(v), mbic_mem_model_inst.mv(v + 16'h1)})
		`CHK(mbic_mem_model_inst.wq.size(), 7)
		foreach (e[i]) `CHK(mbic_mem_model_inst.wq[i], e[i])
		`CHK(o_cc[4], 1'b1)
		mask = 1;
		i_nmi_n = 1;
		`TILL(o_busy, 1'b0)
		$display("entry kind %0d done", k);
	endtask
	// Hang guard, far above the hundred or so cycles the run needs
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			conclude();
		end
	end
	initial begin
		repeat (16) @(negedge i_clk_sys);
		i_arst_n = 1;
		`TILL(o_pc_load_valid, 1'b1)
		`CHK(o_pc_load, {mbic_mem_model_inst.mv(16'hFFFE), mbic_mem_model_inst.mv(16'hFFFF)})
		`CHK(o_cc, 8'hD0)
		`TILL(o_busy, 1'b0)
		$display("restart done");
		i_irq_n = 0;
		repeat (3) @(negedge i_clk_sys);
		i_insn_done = 1;
		@(negedge i_clk_sys);
		i_insn_done = 0;
		i_irq_n = 1;
		i_cc_mask_clear = 1;
		@(negedge i_clk_sys);
		`CHK(o_busy, 1'b0)
		i_cc_mask_clear = 0;
		mask = 0;
		@(negedge i_clk_sys);
		`CHK(o_cc[4], 1'b0)
		$display("mask test done");
		entry(0, 16'hFFF8);
		entry(1, 16'hFFFC);
		entry(2, 16'hFFFA);
		entry(3, 16'hFFFC);
		// halt moved at a falling edge only
		i_halt_n = 0;
		i_insn_done = 1;
		@(negedge i_clk_sys);
		i_insn_done = 0;
		`TILL(o_bus_released, 1'b1)
		`CHK({o_address_lines_oe_n, o_rw_oe_n, o_valid_address_strobe}, 3'b110)
		i_halt_n = 1;
		`TILL(o_bus_released, 1'b0)
		$display("halt test done");
		// brief float, data enable held low
		i_address_float_control = 1;
		i_data_drive_enable = 0;
		repeat (2) @(negedge i_clk_sys);
		`CHK({o_address_lines_oe_n, o_rw_oe_n, o_valid_address_strobe}, 3'b110)
		`CHK({o_bus_released, o_data_lines_oe_n}, 2'b01)
		i_address_float_control = 0;
		i_data_drive_enable = 1;
		repeat (2) @(negedge i_clk_sys);
		$display("float test done");
		conclude();
	end
endmodule // tb_top
bind mbic_bus_ctrl mbic_props mbic_props_inst (.i_clk_sys, .i_arst_n, .i_address_float_control,
	.i_data_drive_enable, .i_halt_n, .i_irq_n, .i_insn_done, .o_address_lines,
	.o_address_lines_oe_n, .o_rw, .o_rw_oe_n, .o_data_lines_oe_n, .o_valid_address_strobe,
	.o_bus_released, .o_cc, .o_busy);
